// file: core/spc_pkg.sv
// spc_pkg: register map, field positions, reset values and prescale codes
// for the serial port control block; no surroundings assumed.
package spc_pkg;
  // apb byte addresses of the two control registers, the buffer and the status register
  localparam logic [7:0] CTRL_ONE_ADDR = 8'h00;
  localparam logic [7:0] CTRL_TWO_ADDR = 8'h04;
  localparam logic [7:0] BUFFER_ADDR = 8'h08;
  localparam logic [7:0] STATUS_ADDR = 8'h0c;
  // control one fields
  localparam int CLK_DIS_BIT = 12;
  localparam int DOUT_DIS_BIT = 11;
  localparam int WIDTH16_BIT = 10;
  localparam int SMP_PHASE_BIT = 9;
  localparam int EDGE_SEL_BIT = 8;
  localparam int SS_EN_BIT = 7;
  localparam int POLARITY_BIT = 6;
  localparam int MASTER_BIT = 5;
  localparam int SEC_LSB = 2;
  localparam int PRI_LSB = 0;
  localparam logic [15:0] CTRL_ONE_MASK = 16'h1fff;
  // control two fields
  localparam int FRAMED_BIT = 15;
  localparam int SYNC_DIR_BIT = 14;
  localparam int SYNC_POL_BIT = 13;
  localparam int SYNC_EDGE_BIT = 1;
  localparam logic [15:0] CTRL_TWO_MASK = 16'he002;
  // status fields
  localparam int ENABLE_BIT = 15;
  localparam int OVERFLOW_BIT = 6;
  localparam int TX_FULL_BIT = 1;
  localparam int RX_FULL_BIT = 0;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  // primary prescale codes and ratios
  localparam logic [1:0] PRI_CODE_1 = 2'h3;
  localparam logic [1:0] PRI_CODE_4 = 2'h2;
  localparam logic [1:0] PRI_CODE_16 = 2'h1;
  localparam logic [6:0] PRI_RATIO_1 = 7'h01;
  localparam logic [6:0] PRI_RATIO_4 = 7'h04;
  localparam logic [6:0] PRI_RATIO_16 = 7'h10;
  localparam logic [6:0] PRI_RATIO_64 = 7'h40;
  localparam logic [3:0] SEC_RATIO_MAX = 4'h8;
  localparam logic [4:0] WORD_BITS = 5'h10;
  localparam logic [4:0] BYTE_BITS = 5'h08;
endpackage

// file: core/spc_prescaler.sv
// spc_prescaler: divides the instruction clock by primary times secondary ratio,
// rounded down to even and at least 2, and gives a tick every half serial-clock period.
// assumes codes are held stable while a transfer runs.
`timescale 1ns/1ps
`default_nettype none
module spc_prescaler (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control
  input wire logic run,
  input wire logic [1:0] primary_prescale,
  input wire logic [2:0] secondary_prescale,
  // half-period tick
  output logic half_tick
);
  typedef struct packed {
    logic [10:0] count;
    logic tick;
  } spc_div_s;
  spc_div_s cur_reg, cur_next;
  logic [10:0] half_len;
  logic [10:0] product;

  function automatic logic [6:0] pri_ratio(input logic [1:0] code);
    if (code == spc_pkg::PRI_CODE_1) begin
      pri_ratio = spc_pkg::PRI_RATIO_1;
    end else if (code == spc_pkg::PRI_CODE_4) begin
      pri_ratio = spc_pkg::PRI_RATIO_4;
    end else if (code == spc_pkg::PRI_CODE_16) begin
      pri_ratio = spc_pkg::PRI_RATIO_16;
    end else begin
      pri_ratio = spc_pkg::PRI_RATIO_64;
    end
  endfunction

  // 111 gives 1, 110 gives 2, ... 000 gives 8
  function automatic logic [3:0] sec_ratio(input logic [2:0] code);
    sec_ratio = spc_pkg::SEC_RATIO_MAX - {1'b0, code};
  endfunction

  // product sets the serial clock; half of it per level, at least one cycle
  always_comb begin
    // widen before multiplying: 64 times 8 does not fit the ratio width
    product = 11'(pri_ratio(primary_prescale)) * 11'(sec_ratio(secondary_prescale));
    half_len = product >> 1;
    cur_next = cur_reg;
    cur_next.tick = 1'b0;
    if (!run) begin
      cur_next.count = 11'h000;
    end else if (cur_reg.count + 11'h001 >= half_len) begin
      cur_next.count = 11'h000;
      cur_next.tick = 1'b1;
    end else begin
      cur_next.count = cur_reg.count + 11'h001;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cur_reg <= '0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign half_tick = cur_reg.tick;
endmodule
`default_nettype wire

// file: core/spc_sync.sv
// spc_sync: three-flop input synchroniser; output changes once the second
// and third stages agree. assumes input is asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module spc_sync (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // pin and clean level
  input wire logic pin_in,
  output logic level
);
  typedef struct packed {
    logic [2:0] stage;
    logic level;
  } spc_sync_s;
  spc_sync_s cur_reg, cur_next;

  always_comb begin
    cur_next = cur_reg;
    cur_next.stage = {cur_reg.stage[1:0], pin_in};
    if (cur_reg.stage[1] == cur_reg.stage[2]) begin
      cur_next.level = cur_reg.stage[2];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cur_reg <= '0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign level = cur_reg.level;
endmodule
`default_nettype wire

// file: core/spc_serial_port.sv
// spc_serial_port: configurable synchronous serial port with apb registers.
// assumes an apb master on clk; pins are split into in, out and enable.
//
// Summary of operation
// - master with clock disable set: shift clock pin released to general I/O.
// - data-out disable set: data output pin undriven; clear: port drives it.
// - width bit one shifts 16 bits per transfer; zero shifts 8 bits.
// - master samples input at end of output time if phase set, else middle.
// - edge bit one: slave output changes active-to-idle; zero: idle-to-active; master output always changes active-to-idle.
// - framed mode ignores the edge bit; software programs it zero.
// - slave with select enable uses the active-low select pin, else ignores it.
// - polarity one: clock idles high; zero: clock idles low.
// - master bit one: port generates the clock; zero: slave.
// - secondary code 111 divides by 1, 110 by 2, 000 by 8.
// - primary code 11 divides by 1, 10 by 4.
// - framed mode turns the select pin into a frame sync pulse.
// - sync direction one: sync is input; zero: port drives sync.
// - sync polarity one: sync active high; zero: active low.
// - sync edge one: sync coincides with first bit; zero: precedes it.
// - unimplemented control bits read as zero.
// - master clock is instruction clock over primary times secondary ratio; an odd product is rounded down to even, at least 2.
// - shift clock pin is output in master role, input in slave role.
// - master starts a full-duplex transfer when software writes the buffer.
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module spc_serial_port (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // shift clock pin
  input wire logic shift_clock_pin_in,
  output logic shift_clock_pin_out,
  output logic shift_clock_pin_oe_n,
  // serial data pins
  input wire logic serial_data_in_pin,
  output logic serial_data_out_pin,
  output logic serial_data_out_pin_oe_n,
  // slave select or frame sync pin
  input wire logic slave_select_pin_in,
  output logic slave_select_pin_out,
  output logic slave_select_pin_oe_n
);
  typedef enum logic [1:0] {ST_IDLE, ST_SYNC, ST_SHIFT} spc_state_e;
  typedef struct packed {
    spc_state_e state;
    logic [15:0] ctrl_one;
    logic [15:0] ctrl_two;
    logic enable;
    logic overflow;
    logic [15:0] tx_buf;
    logic tx_full;
    logic [15:0] rx_buf;
    logic rx_full;
    logic [15:0] shifter;
    logic [4:0] bits_left;
    logic phase;
    logic sampled;
    logic sck_prev;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sck_out;
    logic sck_oe_n;
    logic sdo;
    logic sdo_oe_n;
    logic ss_out;
    logic ss_oe_n;
  } spc_port_s;
  spc_port_s cur_reg, cur_next;

  logic half_tick;
  logic sck_level;
  logic sdi_level;
  logic ss_level;
  logic [15:0] ctrl_one_rd;
  logic [15:0] ctrl_two_rd;
  logic [15:0] status_rd;
  logic master, framed, width16, input_sample_phase, cke, clock_polarity, ss_en;
  logic sync_dir, sync_pol, sync_edge;
  logic slave_selected, slave_frame_seen, lead_edge, trail_edge, out_edge, in_edge;
  logic apb_access;
  logic last_bit;

  spc_prescaler u_prescaler (
    .clk(clk),
    .reset(reset),
    .run(cur_reg.state != ST_IDLE),
    .primary_prescale(cur_reg.ctrl_one[spc_pkg::PRI_LSB +: 2]),
    .secondary_prescale(cur_reg.ctrl_one[spc_pkg::SEC_LSB +: 3]),
    .half_tick(half_tick)
  );

  spc_sync u_sync_sck (
    .clk(clk),
    .reset(reset),
    .pin_in(shift_clock_pin_in),
    .level(sck_level)
  );

  spc_sync u_sync_sdi (
    .clk(clk),
    .reset(reset),
    .pin_in(serial_data_in_pin),
    .level(sdi_level)
  );

  spc_sync u_sync_ss (
    .clk(clk),
    .reset(reset),
    .pin_in(slave_select_pin_in),
    .level(ss_level)
  );

  always_comb begin
    master = cur_reg.ctrl_one[spc_pkg::MASTER_BIT];
    framed = cur_reg.ctrl_two[spc_pkg::FRAMED_BIT];
    width16 = cur_reg.ctrl_one[spc_pkg::WIDTH16_BIT];
    input_sample_phase = cur_reg.ctrl_one[spc_pkg::SMP_PHASE_BIT];
    // framed operation ignores the edge bit
    cke = cur_reg.ctrl_one[spc_pkg::EDGE_SEL_BIT] & ~framed;
    clock_polarity = cur_reg.ctrl_one[spc_pkg::POLARITY_BIT];
    ss_en = cur_reg.ctrl_one[spc_pkg::SS_EN_BIT];
    sync_dir = cur_reg.ctrl_two[spc_pkg::SYNC_DIR_BIT];
    sync_pol = cur_reg.ctrl_two[spc_pkg::SYNC_POL_BIT];
    sync_edge = cur_reg.ctrl_two[spc_pkg::SYNC_EDGE_BIT];
    // unimplemented bits masked off on read
    ctrl_one_rd = cur_reg.ctrl_one & spc_pkg::CTRL_ONE_MASK;
    ctrl_two_rd = cur_reg.ctrl_two & spc_pkg::CTRL_TWO_MASK;
    status_rd = 16'h0000;
    status_rd[spc_pkg::ENABLE_BIT] = cur_reg.enable;
    status_rd[spc_pkg::OVERFLOW_BIT] = cur_reg.overflow;
    status_rd[spc_pkg::TX_FULL_BIT] = cur_reg.tx_full;
    status_rd[spc_pkg::RX_FULL_BIT] = cur_reg.rx_full;
    // slave selected when the pin is not in use, or when it is low
    slave_selected = ~ss_en | ~ss_level;
    slave_frame_seen = (ss_level == sync_pol);
    // slave edges from the synchronised pin; polarity maps level to active
    lead_edge = (sck_level ^ clock_polarity) & ~(cur_reg.sck_prev ^ clock_polarity);
    trail_edge = ~(sck_level ^ clock_polarity) & (cur_reg.sck_prev ^ clock_polarity);
    out_edge = cke ? trail_edge : lead_edge;
    in_edge = cke ? lead_edge : trail_edge;
    apb_access = psel & penable & ~cur_reg.pready;
    last_bit = (cur_reg.bits_left == 5'h01);
  end

  always_comb begin
    cur_next = cur_reg;
    cur_next.pready = 1'b0;
    cur_next.pslverr = 1'b0;
    cur_next.sck_prev = sck_level;
    // apb: one wait state, answer registered
    if (apb_access) begin
      cur_next.pready = 1'b1;
      cur_next.prdata = 32'h00000000;
      if (paddr == spc_pkg::CTRL_ONE_ADDR) begin
        if (pwrite) begin
          cur_next.ctrl_one = pwdata[15:0] & spc_pkg::CTRL_ONE_MASK;
        end else begin
          cur_next.prdata = {16'h0000, ctrl_one_rd};
        end
      end else if (paddr == spc_pkg::CTRL_TWO_ADDR) begin
        if (pwrite) begin
          cur_next.ctrl_two = pwdata[15:0] & spc_pkg::CTRL_TWO_MASK;
        end else begin
          cur_next.prdata = {16'h0000, ctrl_two_rd};
        end
      end else if (paddr == spc_pkg::BUFFER_ADDR) begin
        if (pwrite) begin
          cur_next.tx_buf = pwdata[15:0];
          cur_next.tx_full = 1'b1;
        end else begin
          cur_next.prdata = {16'h0000, cur_reg.rx_buf};
          cur_next.rx_full = 1'b0;
        end
      end else if (paddr == spc_pkg::STATUS_ADDR) begin
        if (pwrite) begin
          cur_next.enable = pwdata[spc_pkg::ENABLE_BIT];
          if (!pwdata[spc_pkg::OVERFLOW_BIT]) begin
            cur_next.overflow = 1'b0;
          end
        end else begin
          cur_next.prdata = {16'h0000, status_rd};
        end
      end else begin
        cur_next.pslverr = 1'b1;
      end
    end

    case (cur_reg.state)
      ST_IDLE: begin
        cur_next.sck_out = clock_polarity;
        cur_next.phase = 1'b0;
        if (framed && !sync_dir) begin
          cur_next.ss_out = ~sync_pol;
        end
        if (cur_reg.enable && !cur_reg.overflow && cur_reg.tx_full && master
            && (!framed || !sync_dir || slave_frame_seen)) begin
          cur_next.shifter = cur_reg.tx_buf;
          cur_next.tx_full = 1'b0;
          cur_next.bits_left = width16 ? spc_pkg::WORD_BITS : spc_pkg::BYTE_BITS;
          cur_next.sdo = width16 ? cur_reg.tx_buf[15] : cur_reg.tx_buf[7];
          if (framed && !sync_dir) begin
            cur_next.ss_out = sync_pol;
          end
          // early sync spends one bit time before the first clock
          cur_next.state = (framed && !sync_edge) ? ST_SYNC : ST_SHIFT;
        end else if (cur_reg.enable && !cur_reg.overflow && !master
                     && (framed ? slave_frame_seen : slave_selected)) begin
          cur_next.shifter = cur_reg.tx_full ? cur_reg.tx_buf : 16'h0000;
          cur_next.tx_full = 1'b0;
          cur_next.bits_left = width16 ? spc_pkg::WORD_BITS : spc_pkg::BYTE_BITS;
          cur_next.sdo = width16 ? cur_reg.tx_buf[15] : cur_reg.tx_buf[7];
          cur_next.state = ST_SHIFT;
        end
      end
      ST_SYNC: begin
        if (half_tick) begin
          cur_next.phase = ~cur_reg.phase;
          if (cur_reg.phase) begin
            cur_next.ss_out = ~sync_pol;
            cur_next.state = ST_SHIFT;
          end
        end
      end
      ST_SHIFT: begin
        if (master && half_tick) begin
          cur_next.phase = ~cur_reg.phase;
          cur_next.sck_out = ~cur_reg.phase ^ clock_polarity;
          if (framed && !sync_dir && sync_edge) begin
            cur_next.ss_out = ~sync_pol;
          end
          // first half: mid-time sample; second half: end-time sample
          if (!cur_reg.phase && !input_sample_phase) begin
            cur_next.sampled = sdi_level;
          end
          if (cur_reg.phase) begin
            cur_next.shifter = {cur_reg.shifter[14:0], input_sample_phase ? sdi_level : cur_reg.sampled};
            cur_next.sdo = width16 ? cur_reg.shifter[14] : cur_reg.shifter[6];
            cur_next.bits_left = cur_reg.bits_left - 5'h01;
          end
        end else if (!master) begin
          if (in_edge) begin
            cur_next.shifter = {cur_reg.shifter[14:0], sdi_level};
            cur_next.bits_left = cur_reg.bits_left - 5'h01;
          end
          if (out_edge) begin
            cur_next.sdo = width16 ? cur_reg.shifter[15] : cur_reg.shifter[7];
          end
          if (!framed && !slave_selected) begin
            cur_next.state = ST_IDLE;
          end
        end
        if (cur_reg.bits_left == 5'h00 || (master && half_tick && cur_reg.phase && last_bit)) begin
          cur_next.state = ST_IDLE;
          if (cur_reg.rx_full) begin
            cur_next.overflow = 1'b1;
          end else begin
            cur_next.rx_buf = (cur_reg.bits_left == 5'h00) ? cur_reg.shifter
                : {cur_reg.shifter[14:0], input_sample_phase ? sdi_level : cur_reg.sampled};
            cur_next.rx_full = 1'b1;
          end
          if (!width16) begin
            cur_next.rx_buf[15:8] = 8'h00;
          end
        end
      end
      default: begin
        cur_next.state = ST_IDLE;
      end
    endcase

    // pin drive, active-low enables
    cur_next.sck_oe_n = ~(cur_reg.enable & master & ~cur_reg.ctrl_one[spc_pkg::CLK_DIS_BIT]);
    cur_next.sdo_oe_n = ~(cur_reg.enable & ~cur_reg.ctrl_one[spc_pkg::DOUT_DIS_BIT]);
    cur_next.ss_oe_n = ~(cur_reg.enable & framed & ~sync_dir);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cur_reg <= '0;
      cur_reg.state <= ST_IDLE;
      cur_reg.sck_oe_n <= 1'b1;
      cur_reg.sdo_oe_n <= 1'b1;
      cur_reg.ss_oe_n <= 1'b1;
      cur_reg.ss_out <= 1'b1;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign prdata = cur_reg.prdata;
  assign pready = cur_reg.pready;
  assign pslverr = cur_reg.pslverr;
  assign shift_clock_pin_out = cur_reg.sck_out;
  assign shift_clock_pin_oe_n = cur_reg.sck_oe_n;
  assign serial_data_out_pin = cur_reg.sdo;
  assign serial_data_out_pin_oe_n = cur_reg.sdo_oe_n;
  assign slave_select_pin_out = cur_reg.ss_out;
  assign slave_select_pin_oe_n = cur_reg.ss_oe_n;
endmodule
`default_nettype wire

// file: verif/spc_serial_port_properties.sv
// spc_serial_port_properties: port checks for the serial port block.
// assumes apb writes take effect at the edge that samples pready.
`timescale 1ns/1ps
`default_nettype none
module spc_serial_port_properties (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins
  input wire logic shift_clock_pin_out,
  input wire logic shift_clock_pin_oe_n,
  input wire logic serial_data_out_pin_oe_n,
  input wire logic slave_select_pin_oe_n
);
  logic [15:0] c1_reg;
  logic [15:0] c2_reg;
  logic en_reg;
  logic [1:0] quiet_reg;
  logic wr_now;
  logic rd_now;
  assign wr_now = psel && penable && pready && pwrite;
  assign rd_now = pready && !pwrite;
  // config shadow; registered pins lag a write, so wait two quiet cycles
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      c1_reg <= 16'h0000;
      c2_reg <= 16'h0000;
      en_reg <= 1'b0;
      quiet_reg <= 2'h0;
    end else begin
      if (wr_now && paddr == spc_pkg::CTRL_ONE_ADDR) begin
        c1_reg <= pwdata[15:0];
      end
      if (wr_now && paddr == spc_pkg::CTRL_TWO_ADDR) begin
        c2_reg <= pwdata[15:0];
      end
      if (wr_now && paddr == spc_pkg::STATUS_ADDR) begin
        en_reg <= pwdata[spc_pkg::ENABLE_BIT];
      end
      quiet_reg <= wr_now ? 2'h0 : (quiet_reg == 2'h3 ? 2'h3 : quiet_reg + 2'h1);
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  sequence acc_start;
    psel && !penable ##1 psel && penable;
  endsequence
  a_ready_wait: assert property (acc_start |-> ##[0:1] pready)
    else $error("apb answer late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_read_upper: assert property (rd_now |-> prdata[31:16] == 16'h0000)
    else $error("read upper half not zero");
  a_one_resv: assert property (
    rd_now && paddr == spc_pkg::CTRL_ONE_ADDR |-> prdata[15:13] == 3'h0)
    else $error("control one reserved bits set");
  a_two_resv: assert property (
    rd_now && paddr == spc_pkg::CTRL_TWO_ADDR |-> prdata[12:2] == 11'h000 && !prdata[0])
    else $error("control two reserved bits set");
  a_bad_addr: assert property (pready |->
    pslverr == (paddr > spc_pkg::STATUS_ADDR || paddr[1:0] != 2'h0))
    else $error("slave error wrong");
  a_sck_drive: assert property (quiet_reg[1] |-> shift_clock_pin_oe_n ==
    !(en_reg && c1_reg[spc_pkg::MASTER_BIT] && !c1_reg[spc_pkg::CLK_DIS_BIT]))
    else $error("clock pin drive wrong");
  a_sdo_drive: assert property (quiet_reg[1] |->
    serial_data_out_pin_oe_n == !(en_reg && !c1_reg[spc_pkg::DOUT_DIS_BIT]))
    else $error("data pin drive wrong");
  a_sync_drive: assert property (quiet_reg[1] |-> slave_select_pin_oe_n ==
    !(en_reg && c2_reg[spc_pkg::FRAMED_BIT] && !c2_reg[spc_pkg::SYNC_DIR_BIT]))
    else $error("sync pin drive wrong");
  a_sck_idle: assert property (
    quiet_reg[1] && !en_reg |-> shift_clock_pin_out == c1_reg[spc_pkg::POLARITY_BIT])
    else $error("clock idle level wrong");
endmodule
`default_nettype wire

// file: verif/spc_far_peripheral.sv
// spc_far_peripheral: serial peripheral on the far side of the port.
// assumes the port clocks it; shifts its own word out msb first.
`timescale 1ns/1ps
`default_nettype none
module spc_far_peripheral (
  // link pins
  input wire logic sck,
  input wire logic sdo,
  input wire logic cpol,
  output logic sdi,
  // word captured for the bench
  output logic [15:0] got
);
  logic [15:0] tx_reg;
  initial begin
    tx_reg = 16'h0000;
    got = 16'h0000;
  end
  task automatic load(input logic [15:0] v);
    tx_reg = v;
    got = 16'h0000;
  endtask
  assign sdi = tx_reg[15];
  // take on leading edge, show next on trailing: stable at mid and end samples
  always @(sck) begin
    if (sck !== cpol) begin
      got = {got[14:0], sdo};
    end else begin
      tx_reg = {tx_reg[14:0], ~tx_reg[0]};
    end
  end
endmodule
`default_nettype wire

// file: verif/spc_serial_port_tb.sv
// spc_serial_port_tb: apb-driven checks of config, pins and transfers.
// assumes a pulled-up data and select line and a far peripheral model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, x, g) begin \
  checked++; \
  if ((g) !== (x)) begin \
    fails++; \
    $display("BAD %s expected %0h seen %0h", nm, x, g); \
  end \
end
module spc_serial_port_tb;
  logic clk, reset, psel, penable, pwrite, pready, pslverr, far_cpol, sdo_wire;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic shift_clock_pin_in, shift_clock_pin_out, shift_clock_pin_oe_n;
  logic serial_data_in_pin, serial_data_out_pin, serial_data_out_pin_oe_n;
  logic slave_select_pin_in, slave_select_pin_out, slave_select_pin_oe_n;
  logic [15:0] far_got;
  logic e;
  int fails, checked, cycles, edges;
  logic [15:0] pin_cfg [4] = '{16'h0060, 16'h1020, 16'h0820, 16'h0080};
  logic [1:0] pin_exp [4] = '{2'h0, 2'h2, 2'h1, 2'h2};
  assign shift_clock_pin_in = shift_clock_pin_oe_n ? far_cpol : shift_clock_pin_out;
  assign sdo_wire = serial_data_out_pin_oe_n ? 1'b1 : serial_data_out_pin;
  assign slave_select_pin_in = slave_select_pin_oe_n ? 1'b1 : slave_select_pin_out;
  spc_serial_port spc_serial_port_i (.clk, .reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .shift_clock_pin_in, .shift_clock_pin_out,
    .shift_clock_pin_oe_n, .serial_data_in_pin, .serial_data_out_pin,
    .serial_data_out_pin_oe_n, .slave_select_pin_in, .slave_select_pin_out,
    .slave_select_pin_oe_n);
  spc_far_peripheral spc_far_peripheral_i (.sck(shift_clock_pin_in), .sdo(sdo_wire),
    .cpol(far_cpol), .sdi(serial_data_in_pin), .got(far_got));
  always #50 clk = ~clk;
  always @(shift_clock_pin_out) edges++;
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      end_of_test();
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic er);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // look between edges so the registered answer has settled
    do @(negedge clk); while (pready !== 1'b1);
    r = prdata;
    er = pslverr;
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [15:0] x);
    apb(1'b0, a, 32'h0, q, e);
    `CHK(nm, x, q[15:0])
  endtask
  task automatic xfer(input logic [15:0] c1, input logic [15:0] c2, input logic [15:0] tx,
                      input logic [15:0] rx, input int half, input logic rxok);
    int n;
    logic seen;
    logic [15:0] m;
    m = c1[spc_pkg::WIDTH16_BIT] ? 16'hffff : 16'h00ff;
    far_cpol = c1[spc_pkg::POLARITY_BIT];
    wr(spc_pkg::CTRL_ONE_ADDR, {16'h0000, c1});
    wr(spc_pkg::CTRL_TWO_ADDR, {16'h0000, c2});
    repeat (2) @(posedge clk);
    `CHK("clock idle", far_cpol, shift_clock_pin_out)
    spc_far_peripheral_i.load(m[8] ? rx : {rx[7:0], 8'h00});
    edges = 0;
    seen = 1'b0;
    wr(spc_pkg::BUFFER_ADDR, {16'h0000, tx});
    while (shift_clock_pin_out === far_cpol) begin
      @(posedge clk);
      if (slave_select_pin_out === c2[spc_pkg::SYNC_POL_BIT]) seen = 1'b1;
    end
    n = 0;
    while (shift_clock_pin_out !== far_cpol) begin
      @(posedge clk);
      n++;
    end
    `CHK("half period", half, n)
    do apb(1'b0, spc_pkg::STATUS_ADDR, 32'h0, q, e); while (q[0] !== 1'b1);
    `CHK("clock edges", m[8] ? 32 : 16, edges)
    `CHK("word sent", tx & m, far_got & m)
    apb(1'b0, spc_pkg::BUFFER_ADDR, 32'h0, q, e);
    if (rxok) `CHK("word got", rx & m, q[15:0])
    if (c2[spc_pkg::FRAMED_BIT]) `CHK("sync first", 1'b1, seen)
  endtask
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    far_cpol = 1'b0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rdc("one reset", spc_pkg::CTRL_ONE_ADDR, 16'h0000);
    rdc("two reset", spc_pkg::CTRL_TWO_ADDR, 16'h0000);
    wr(spc_pkg::CTRL_ONE_ADDR, 32'hffffffff);
    rdc("one mask", spc_pkg::CTRL_ONE_ADDR, 16'h1fff);
    wr(spc_pkg::CTRL_TWO_ADDR, 32'hfffffffe);
    rdc("two mask", spc_pkg::CTRL_TWO_ADDR, 16'he002);
    apb(1'b0, 8'h10, 32'h0, q, e);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 32'h0, q)
    wr(spc_pkg::CTRL_TWO_ADDR, 32'h0);
    wr(spc_pkg::STATUS_ADDR, 32'h00008000);
    // last entry is slave role, sample phase kept clear
    for (int i = 0; i < 4; i++) begin
      wr(spc_pkg::CTRL_ONE_ADDR, {16'h0000, pin_cfg[i]});
      repeat (2) @(posedge clk);
      `CHK("pin drive", pin_exp[i], {shift_clock_pin_oe_n, serial_data_out_pin_oe_n})
    end
    xfer(16'h0022, 16'h0000, 16'h00a5, 16'h003c, 16, 1'b1);
    xfer(16'h077d, 16'h0000, 16'h1234, 16'hc3a5, 8, 1'b1);
    xfer(16'h003b, 16'h0000, 16'h0096, 16'h0000, 1, 1'b0);
    xfer(16'h003c, 16'h0000, 16'h0081, 16'h007e, 32, 1'b1);
    xfer(16'h0022, 16'ha000, 16'h005a, 16'h00c6, 16, 1'b1);
    `CHK("sync out drive", 1'b0, slave_select_pin_oe_n)
    wr(spc_pkg::CTRL_TWO_ADDR, 32'h0000c000);
    repeat (2) @(posedge clk);
    `CHK("sync in drive", 1'b1, slave_select_pin_oe_n)
    end_of_test();
  end
endmodule
bind spc_serial_port spc_serial_port_properties spc_serial_port_properties_i (.clk,
  .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .shift_clock_pin_out, .shift_clock_pin_oe_n, .serial_data_out_pin_oe_n,
  .slave_select_pin_oe_n);
`default_nettype wire
